//--- shared/prio_params.svh
`ifndef PRIO_PARAMS_SVH
`define PRIO_PARAMS_SVH

// register indices on the plain register port
`define PRIO_ADDR_W 4
`define PRIO_OFS_LEVELS 4'h0
`define PRIO_OFS_ENABLE 4'h1
`define PRIO_OFS_STATUS 4'h2

// data and field layout
`define PRIO_DATA_W 16
`define PRIO_LVL_W 3
`define PRIO_NSRC 3
`define PRIO_TX_LSB 12
`define PRIO_RX_LSB 8
`define PRIO_EXT_LSB 4
`define PRIO_IMPL_MASK 16'h7770

// enable bits sit at the top of the enable register
`define PRIO_EN_TX_BIT 15
`define PRIO_EN_RX_BIT 14
`define PRIO_EN_EXT_BIT 13

// reset values
`define PRIO_LVL_RST 3'h4
`define PRIO_EN_RST 3'h0

`endif

//--- shared/prio_pkg.sv
package prio_pkg;

  typedef logic [2:0] level_t;
  typedef logic [15:0] word_t;

  // source order used for every per-source vector
  typedef enum logic [1:0] {
    SRC_TX,
    SRC_RX,
    SRC_EXT
  } src_e;

endpackage : prio_pkg

//--- shared/field_if.sv
`timescale 1ns/1ps
`default_nettype none

interface field_if;
  logic we;
  logic [2:0] wd;
  logic [2:0] q;

  modport owner (input we, input wd, output q);
  modport user (output we, output wd, input q);
endinterface : field_if

`default_nettype wire

//--- rtl/prio_field.sv
`timescale 1ns/1ps
`default_nettype none
`include "prio_params.svh"

module prio_field
  import prio_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  field_if.owner fld
);

  level_t lvl_ff;
  level_t nxt_lvl;

  // new level on write, else hold
  assign nxt_lvl = fld.we ? fld.wd : lvl_ff;

  // level register, level 4 after reset
  // [R4] reset to level four
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      lvl_ff <= `PRIO_LVL_RST;
    else
      lvl_ff <= nxt_lvl;
  end

  assign fld.q = lvl_ff;

endmodule : prio_field

`default_nettype wire

//--- rtl/prio_regs.sv
// Operation
// [R1] three 3-bit fields at 14-12, 10-8, 6-4
// [R2] field value is its priority level
// [R3] level zero blocks the source request
// [R4] every field resets to level four
// [R5] unused bits 15, 11, 7, 3-0 read zero
// [R6] request only when source enable set
// [R7] unused writes dropped, fields read back
`timescale 1ns/1ps
`default_nettype none
`include "prio_params.svh"

module prio_regs
  import prio_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [2:0] irq_flag_i,
  output logic [15:0] rdata_o,
  output logic [2:0] irq_req_o,
  output logic [2:0] top_level_o,
  output logic [8:0] levels_o
);

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------

  logic sel_levels;
  logic sel_enable;
  logic sel_status;
  logic wr_levels;
  logic wr_enable;

  assign sel_levels = (addr_i == `PRIO_OFS_LEVELS);
  assign sel_enable = (addr_i == `PRIO_OFS_ENABLE);
  assign sel_status = (addr_i == `PRIO_OFS_STATUS);
  assign wr_levels = wr_i & sel_levels;
  assign wr_enable = wr_i & sel_enable;

  // ------------------------------------------------------------
  // priority fields
  // ------------------------------------------------------------

  field_if fld [`PRIO_NSRC] ();
  level_t lvl [`PRIO_NSRC];

  genvar g;
  generate
    for (g = 0; g < `PRIO_NSRC; g++)
    begin : g_fld
      localparam int LSB = `PRIO_TX_LSB - 4 * g;
      // [R1] one stored field per source
      assign fld[g].we = wr_levels;
      assign fld[g].wd = wdata_i[LSB +: `PRIO_LVL_W];
      assign lvl[g] = fld[g].q;
      prio_field u_field (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .fld (fld[g])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // enable register
  // ------------------------------------------------------------

  logic [2:0] en_ff;
  logic [2:0] nxt_en;
  logic [2:0] wr_en_bits;

  assign wr_en_bits = {wdata_i[`PRIO_EN_EXT_BIT], wdata_i[`PRIO_EN_RX_BIT],
                       wdata_i[`PRIO_EN_TX_BIT]};
  assign nxt_en = wr_enable ? wr_en_bits : en_ff;

  // enable bits, all off after reset
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      en_ff <= `PRIO_EN_RST;
    else
      en_ff <= nxt_en;
  end

  // ------------------------------------------------------------
  // request gating and highest level
  // ------------------------------------------------------------

  logic [2:0] nxt_req;
  logic [2:0] req_ff;
  level_t nxt_top;
  level_t top_ff;
  level_t cand [`PRIO_NSRC];

  generate
    for (g = 0; g < `PRIO_NSRC; g++)
    begin : g_req
      // [R3] zero level keeps the request off
      // [R6] enable bit must be set
      assign nxt_req[g] = irq_flag_i[g] & en_ff[g] & (lvl[g] != 3'h0);
      // [R2] level of a live request, else zero
      assign cand[g] = nxt_req[g] ? lvl[g] : 3'h0;
    end
  endgenerate

  // highest live level, zero when nothing requests
  assign nxt_top = (cand[0] >= cand[1] && cand[0] >= cand[2]) ? cand[0] :
                   (cand[1] >= cand[2]) ? cand[1] : cand[2];

  // registered request lines
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      req_ff <= 3'h0;
      top_ff <= 3'h0;
    end
    else
    begin
      req_ff <= nxt_req;
      top_ff <= nxt_top;
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------

  word_t rd_levels;
  word_t rd_enable;
  word_t rd_status;
  word_t nxt_rdata;
  word_t rdata_ff;

  // [R5] unused bits tied to zero
  // [R7] fields read back their stored value
  assign rd_levels = {1'b0, lvl[0], 1'b0, lvl[1], 1'b0, lvl[2], 4'h0};
  assign rd_enable = {en_ff[0], en_ff[1], en_ff[2], 13'h0000};
  assign rd_status = {9'h000, top_ff, 1'b0, req_ff};
  assign nxt_rdata = !rd_i ? 16'h0000 :
                     sel_levels ? rd_levels :
                     sel_enable ? rd_enable :
                     sel_status ? rd_status : 16'h0000;

  // read data one cycle after the strobe only
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
      rdata_ff <= 16'h0000;
    else
      rdata_ff <= nxt_rdata;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------

  assign rdata_o = rdata_ff;
  assign irq_req_o = req_ff;
  assign top_level_o = top_ff;
  assign levels_o = {lvl[2], lvl[1], lvl[0]};

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // reset level seen at the previous edge, marks the first cycle after release
  logic past_rst_ff;
  always_ff @(posedge sys_clk_i)
  begin
    past_rst_ff <= sys_rst_i;
  end

  // [R1] written field appears on level output
  a_field_write: assert property (wr_levels |=> levels_o[2:0] == $past(wdata_i[14:12]) // [R1]
    && levels_o[5:3] == $past(wdata_i[10:8]) && levels_o[8:6] == $past(wdata_i[6:4]))
    else $error("field write not stored");

  // [R2] highest live level reported
  // request and top level lag the stored level by one cycle, so compare with the old level
  a_top_level: assert property (irq_req_o[0] |-> top_level_o >= $past(levels_o[2:0])) // [R2]
    else $error("top level below a live request");

  // [R3] zero level never requests
  a_zero_block: assert property (levels_o[2:0] == 3'h0 |=> !irq_req_o[0]) // [R3]
    else $error("disabled source requested");

  // [R4] level four after reset
  a_reset_lvl: assert property (past_rst_ff && !sys_rst_i |-> levels_o == 9'h124) // [R4]
    else $error("reset level not four");

  // [R5] unused bits read zero
  a_unused_zero: assert property (rd_i && sel_levels |=> (rdata_o & 16'h888F) == 16'h0000) // [R5]
    else $error("unused bit read nonzero");

  // [R6] request needs its enable
  a_need_enable: assert property (!en_ff[1] |=> !irq_req_o[1]) // [R6]
    else $error("request without enable");

  // [R7] level read returns stored fields
  a_read_back: assert property (rd_i && sel_levels |=> rdata_o == {1'b0, $past(levels_o[2:0]), // [R7]
    1'b0, $past(levels_o[5:3]), 1'b0, $past(levels_o[8:6]), 4'h0})
    else $error("read back mismatch");

  // idle read data is zero
  a_idle_rdata: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data outside read cycle");

  c_tx_req: cover property (irq_req_o[0] && top_level_o == 3'h7);
  c_all_req: cover property (irq_req_o == 3'h7);
  c_disable: cover property (wr_levels && wdata_i[6:4] == 3'h0 ##1 irq_flag_i[2] && en_ff[2]);

endmodule : prio_regs

`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "prio_params.svh"

module testbench
  import prio_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  word_t wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [2:0] flags = 3'h0;
  word_t rdata;
  logic [2:0] irq_req;
  level_t top_level;
  logic [8:0] levels;
  int err_total = 0;
  int compares = 0;

  // device under test
  prio_regs i_prio_regs (
    .sys_clk_i(sys_clk),
    .sys_rst_i(sys_rst),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr),
    .rd_i(rd),
    .irq_flag_i(flags),
    .rdata_o(rdata),
    .irq_req_o(irq_req),
    .top_level_o(top_level),
    .levels_o(levels)
  );

  // 20 MHz clock
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input word_t seen, input word_t exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write strobe
  task automatic wr_reg(input logic [3:0] a, input word_t d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg

  // one-cycle read strobe, data only in the following cycle
  task automatic rd_reg(input logic [3:0] a, input word_t exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    @(negedge sys_clk);
    check(rdata, exp);
    @(negedge sys_clk);
    check(rdata, 16'h0000);
  endtask : rd_reg

  // let registered requests settle
  task automatic wait_req();
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : wait_req

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial
  begin
    int i;
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check({7'h00, levels}, 16'h0124);
    rd_reg(`PRIO_OFS_LEVELS, 16'h4440);
    wr_reg(`PRIO_OFS_LEVELS, 16'hFFFF);
    rd_reg(`PRIO_OFS_LEVELS, 16'h7770);
    wr_reg(`PRIO_OFS_LEVELS, 16'h7100);
    @(negedge sys_clk);
    check({7'h00, levels}, 16'h000F);
    rd_reg(`PRIO_OFS_LEVELS, 16'h7100);
    wr_reg(`PRIO_OFS_ENABLE, 16'hFFFF);
    rd_reg(`PRIO_OFS_ENABLE, 16'hE000);
    @(posedge sys_clk);
    flags <= 3'h7;
    wait_req();
    check({13'h0000, irq_req}, 16'h0003);
    check({13'h0000, top_level}, 16'h0007);
    rd_reg(`PRIO_OFS_STATUS, 16'h0073);
    wr_reg(`PRIO_OFS_STATUS, 16'h0000);
    rd_reg(`PRIO_OFS_STATUS, 16'h0073);
    rd_reg(4'hF, 16'h0000);
    wr_reg(`PRIO_OFS_ENABLE, 16'h0000);
    wait_req();
    check({13'h0000, irq_req}, 16'h0000);
    // sweep every level on the transmitter source alone
    wr_reg(`PRIO_OFS_ENABLE, 16'h8000);
    for (i = 0; i < 8; i++)
    begin
      wr_reg(`PRIO_OFS_LEVELS, {1'b0, 3'(i), 12'h000});
      wait_req();
      check({13'h0000, irq_req}, {15'h0000, i != 0});
      check({13'h0000, top_level}, {13'h0000, 3'(i)});
    end
    // external source alone, then its level dropped to zero under a live flag
    wr_reg(`PRIO_OFS_ENABLE, 16'hE000);
    wr_reg(`PRIO_OFS_LEVELS, 16'h0070);
    wait_req();
    check({7'h00, levels}, 16'h01C0);
    check({13'h0000, irq_req}, 16'h0004);
    check({13'h0000, top_level}, 16'h0007);
    rd_reg(`PRIO_OFS_STATUS, 16'h0074);
    wr_reg(`PRIO_OFS_LEVELS, 16'h0000);
    wait_req();
    check({13'h0000, irq_req}, 16'h0000);
    check({13'h0000, top_level}, 16'h0000);
    // second reset in mid-run
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(negedge sys_clk);
    check({7'h00, levels}, 16'h0124);
    check({13'h0000, irq_req}, 16'h0000);
    check({13'h0000, top_level}, 16'h0000);
    final_report();
  end

  // watchdog against a hung sequence
  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    final_report();
  end
endmodule : testbench

`default_nettype wire
